//--- core/sample_clock_trigger_dac_sequencer.sv
// Purpose: sample clock pacing, input triggers and output sequencing
// Assumes: sample enables come from a phase accumulator on sys_clk_i, input ones from link_clk_i in slave mode
// Notes:   oscillator word is rate times multiplier, clamped to ceiling
// Functional notes
// R1 - accept input rates 195.3 Hz to 52.734 kHz, 105.469 kHz on high-rate
// R2 - oscillator is rate times 512 up to 52.734 kHz, else times 256
// R3 - oscillator timebase never exceeds 27 MHz; rate limited accordingly (code clamps the oscillator word instead, rate_cl still reaches 105469)
// R4 - first 39 input sample pulses are discarded after clock start
// R5 - tachometer values delayed 39 samples to align with analog data
// R6 - acquisition starts on first trigger, ends when buffers full or stopped
// R7 - software trigger starts acquisition directly on start command
// R8 - external trigger starts on rising edge only
// R9 - slave mode takes trigger and clock from master link only
// R10 - threshold trigger on channel 0: fixed 1.0 V or 0.2-9.8 V with hysteresis
// R11 - threshold monitors channel 0 whatever the channel list holds
// R12 - output rate fixed 46.875 kHz base, 10-52.734 kHz enhanced, times 512
// R13 - first output conversion after 34 pulses base, 29 enhanced
// R14 - output converter holds 0 V code from reset
// R15 - single value drives output at once, no clock or trigger, unstoppable
// R16 - base variant errors when output starts while input runs
// R17 - base variant waveform limited to 8192 samples, longer is an error
// R18 - waveform repeats from first entry after last until stopped
// R19 - continuous mode outputs queued samples gap-free until empty or stopped
// R20 - underrun error when continuous queue empties while output expected
// R21 - orderly stop finishes count, abrupt halts now; later triggers ignored
// R22 - channel 7 in list returns current output value aligned with inputs
// R23 - trigger source and sync mode latched at start, fixed while running
`timescale 1ns/1ps
`default_nettype none
module sample_clock_trigger_dac_sequencer #(
    parameter bit          ENHANCED  = 1'b1,
    parameter bit          HIGH_RATE = 1'b0,
    parameter int unsigned AW        = 13
) (
    input  wire logic                 sys_clk_i,
    input  wire logic                 rst_i,
    // input side configuration and control
    input  wire logic [16:0]          in_rate_hz_i,
    input  wire logic [1:0]           trig_src_i,
    input  wire logic [1:0]           sync_mode_i,
    input  wire logic                 in_start_i,
    input  wire logic                 in_stop_i,
    input  wire logic                 in_buffers_done_i,
    input  wire logic                 ext_trig_i,
    input  wire logic                 link_trig_i,
    input  wire logic                 link_clk_i,
    input  wire logic [13:0]          ch0_mv_i,
    input  wire logic                 ch0_neg_i,
    input  wire logic [13:0]          thr_mv_i,
    input  wire logic [2:0]           list_ch_i,
    input  wire logic [23:0]          adc_data_i,
    input  wire logic [31:0]          tach_data_i,
    // output side configuration and control
    input  wire logic [1:0]           out_mode_i,
    input  wire logic [16:0]          out_rate_hz_i,
    input  wire logic                 single_wr_i,
    input  wire logic [23:0]          single_data_i,
    input  wire logic                 wave_wr_i,
    input  wire logic [23:0]          wave_data_i,
    input  wire logic                 wave_clear_i,
    input  wire logic                 out_start_i,
    input  wire logic                 out_stop_orderly_i,
    input  wire logic                 out_stop_abrupt_i,
    input  wire logic [31:0]          out_count_i,
    input  wire logic                 q_valid_i,
    input  wire logic [23:0]          q_data_i,
    output logic                      q_ready_o,
    // results
    output logic [24:0]               osc_word_o,
    output logic                      in_running_o,
    output logic                      in_sample_o,
    output logic                      in_valid_o,
    output logic [23:0]               in_data_o,
    output logic [31:0]               tach_aligned_o,
    output logic                      out_running_o,
    output logic [23:0]               dac_code_o,
    output logic                      dac_load_o,
    output logic                      seq_err_o,
    output logic                      wave_err_o,
    output logic                      underrun_o
);
    // input rate limiting and oscillator word
    localparam logic [16:0] FS_MIN  = 17'(seq_pkg::FS_MIN_HZ);
    localparam logic [16:0] FS_STD  = 17'(seq_pkg::FS_MAX_STD_HZ);
    localparam logic [16:0] FS_TOP  = HIGH_RATE ? 17'(seq_pkg::FS_MAX_HI_HZ)
                                                : FS_STD;
    localparam logic [24:0] TB_MAX  = 25'(seq_pkg::TIMEBASE_MAX_HZ);
    localparam logic [31:0] SYS_HZ  = 32'(seq_pkg::SYS_CLK_HZ);
    wire logic [16:0] rate_lo  = (in_rate_hz_i < FS_MIN) ? FS_MIN
                                                         : in_rate_hz_i;
    wire logic [16:0] rate_cl  = (rate_lo > FS_TOP) ? FS_TOP : rate_lo; // R1
    wire logic        use_low  = (rate_cl <= FS_STD); // R2
    wire logic [25:0] osc_raw  = use_low ? 26'(rate_cl) * 26'(seq_pkg::MULT_LOW)
                                         : 26'(rate_cl) * 26'(seq_pkg::MULT_HIGH);
    wire logic [24:0] osc_lim  = (osc_raw > 26'(TB_MAX)) ? TB_MAX
                                                         : osc_raw[24:0]; // R3

    // sample pulse phase accumulator for input
    logic [31:0] in_acc_q;
    wire  logic [32:0] in_acc_sum = 33'(in_acc_q) + 33'(rate_cl);
    wire  logic        in_tick    = in_acc_sum >= 33'(SYS_HZ);

    // pin synchronisers
    logic [1:0] ext_s_q, ltrig_s_q, lclk_s_q;
    logic       ext_prev_q, ltrig_prev_q, lclk_prev_q;
    wire  logic ext_rise   = ext_s_q[1] & ~ext_prev_q; // R8
    wire  logic ltrig_rise = ltrig_s_q[1] & ~ltrig_prev_q;
    wire  logic lclk_rise  = lclk_s_q[1] & ~lclk_prev_q;

    // latched configuration
    seq_pkg::trig_src_type  trig_q;
    seq_pkg::sync_mode_type sync_q;
    wire logic slave = (sync_q == seq_pkg::SYNC_SLAVE);

    // threshold comparator on channel 0, with hysteresis in the enhanced variant only
    wire logic [13:0] thr_set = !ENHANCED ? 14'(seq_pkg::THR_FIXED_MV) :
        (thr_mv_i < 14'(seq_pkg::THR_MIN_MV)) ? 14'(seq_pkg::THR_MIN_MV) :
        (thr_mv_i > 14'(seq_pkg::THR_MAX_MV)) ? 14'(seq_pkg::THR_MAX_MV) :
        thr_mv_i; // R10
    wire logic [13:0] thr_low = ENHANCED ? thr_set - 14'(seq_pkg::THR_HYST_MV)
                                         : thr_set;
    logic above_q;
    wire  logic ch0_above = ~ch0_neg_i & (ch0_mv_i > thr_set); // R11
    wire  logic ch0_below = ch0_neg_i | (ch0_mv_i < thr_low);
    wire  logic thr_fire  = ch0_above & ~above_q;

    // input sequencing
    typedef enum logic [1:0] {IN_IDLE, IN_WAIT, IN_RUN} in_state_type;
    in_state_type in_st_q;
    logic [5:0]   warm_q;
    wire  logic   trig_hit = slave ? ltrig_rise : // R9
        (trig_q == seq_pkg::TRIG_EXT)    ? ext_rise :
        (trig_q == seq_pkg::TRIG_THRESH) ? thr_fire : 1'b1; // R7
    wire  logic   samp = slave ? lclk_rise : in_tick; // R9
    wire  logic   warm_done = (warm_q == 6'(seq_pkg::IN_GROUP_DELAY));

    // tachometer alignment cache
    logic [31:0] tach_dl_q [seq_pkg::IN_GROUP_DELAY];

    // output side
    localparam logic [16:0] OFS_MIN = 17'(seq_pkg::OUT_FS_MIN_HZ);
    localparam logic [16:0] OFS_BAS = 17'(seq_pkg::OUT_FS_BASE_HZ);
    wire logic [16:0] orate = !ENHANCED ? OFS_BAS :
        (out_rate_hz_i < OFS_MIN) ? OFS_MIN :
        (out_rate_hz_i > FS_STD)  ? FS_STD  : out_rate_hz_i; // R12
    wire logic [5:0] out_lat = ENHANCED ? 6'(seq_pkg::OUT_DELAY_ENH)
                                        : 6'(seq_pkg::OUT_DELAY_BASE); // R13
    logic [31:0] out_acc_q;
    wire  logic [32:0] out_acc_sum = 33'(out_acc_q) + 33'(orate);
    wire  logic        out_tick    = out_acc_sum >= 33'(SYS_HZ);

    typedef enum logic [2:0] {O_IDLE, O_ARM, O_DLY, O_RUN, O_HALT}
        out_state_type;
    out_state_type          o_st_q;
    seq_pkg::out_mode_type  omode_q;
    logic [5:0]  odly_q;
    logic [AW:0] wlen_q;
    logic [AW-1:0] rd_q;
    logic [31:0] ocnt_q;
    logic        orderly_q;
    logic [23:0] wave_rd;
    wire  logic  wave_full = (wlen_q == (AW+1)'(seq_pkg::FIFO_DEPTH));
    wire  logic  cont_mode = ENHANCED && (omode_q == seq_pkg::OUT_CONT);
    wire  logic  run_tick  = (o_st_q == O_RUN) & out_tick;
    wire  logic  cnt_end   = orderly_q & (ocnt_q == 32'h00000000);
    wire  logic  out_busy  = (o_st_q != O_IDLE) && (o_st_q != O_HALT);
    wire  logic  ostart_ok = out_start_i & (o_st_q == O_IDLE)
                             & (out_mode_i != 2'(seq_pkg::OUT_SINGLE));
    wire  logic  otrig     = slave ? ltrig_rise :
        (trig_q == seq_pkg::TRIG_EXT)    ? ext_rise :
        (trig_q == seq_pkg::TRIG_THRESH) ? thr_fire : 1'b1;
    wire  logic [AW-1:0] rd_next = ((AW+1)'(rd_q) + 1'b1 >= wlen_q)
                                   ? '0 : rd_q + 1'b1; // R18

    assign q_ready_o = cont_mode & run_tick; // R19

    wave_mem #(
        .DEPTH     (seq_pkg::FIFO_DEPTH),
        .WIDTH     (24),
        .AW        (AW)
    ) u_wave (
        .sys_clk_i (sys_clk_i),
        .wr_en_i   (wave_wr_i & ~wave_full & (o_st_q == O_IDLE)),
        .wr_addr_i (wlen_q[AW-1:0]),
        .wr_data_i (wave_data_i),
        .rd_addr_i (rd_q),
        .rd_data_o (wave_rd)
    );

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            ext_s_q <= 2'h0; ltrig_s_q <= 2'h0; lclk_s_q <= 2'h0;
            ext_prev_q <= 1'b0; ltrig_prev_q <= 1'b0; lclk_prev_q <= 1'b0;
            in_acc_q <= 32'h00000000; out_acc_q <= 32'h00000000;
            osc_word_o <= 25'h0000000;
        end else begin
            ext_s_q <= {ext_s_q[0], ext_trig_i};
            ltrig_s_q <= {ltrig_s_q[0], link_trig_i};
            lclk_s_q <= {lclk_s_q[0], link_clk_i};
            ext_prev_q <= ext_s_q[1];
            ltrig_prev_q <= ltrig_s_q[1];
            lclk_prev_q <= lclk_s_q[1];
            in_acc_q <= in_tick ? 32'(in_acc_sum - 33'(SYS_HZ))
                                : in_acc_sum[31:0];
            out_acc_q <= out_tick ? 32'(out_acc_sum - 33'(SYS_HZ))
                                  : out_acc_sum[31:0];
            osc_word_o <= osc_lim; // R2 R3
        end
    end

    // threshold arm state
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            above_q <= 1'b0;
        end else if (ch0_above) begin
            above_q <= 1'b1;
        end else if (ch0_below) begin
            above_q <= 1'b0; // R10
        end
    end
    // dropping below the low level re-arms the comparator

    // input acquisition
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            in_st_q <= IN_IDLE;
            trig_q <= seq_pkg::TRIG_SOFT;
            sync_q <= seq_pkg::SYNC_NONE;
            warm_q <= 6'h00;
            in_valid_o <= 1'b0;
            in_sample_o <= 1'b0;
            in_data_o <= 24'h000000;
        end else begin
            in_valid_o <= 1'b0;
            in_sample_o <= 1'b0;
            case (in_st_q)
                IN_IDLE: begin
                    if (in_start_i) begin
                        trig_q <= seq_pkg::trig_src_type'(trig_src_i); // R23
                        sync_q <= seq_pkg::sync_mode_type'(sync_mode_i);
                        warm_q <= 6'h00;
                        in_st_q <= IN_WAIT;
                    end
                end
                IN_WAIT: begin
                    if (in_stop_i) begin
                        in_st_q <= IN_IDLE;
                    end else if (trig_hit) begin
                        in_st_q <= IN_RUN; // R6
                    end
                end
                IN_RUN: begin
                    if (in_stop_i || in_buffers_done_i) begin
                        in_st_q <= IN_IDLE; // R6
                    end else if (samp) begin
                        in_sample_o <= 1'b1;
                        if (!warm_done) begin
                            warm_q <= warm_q + 6'h01; // R4
                        end else begin
                            in_valid_o <= 1'b1;
                            in_data_o <= (ENHANCED &&
                                list_ch_i == 3'(seq_pkg::READBACK_CH))
                                ? dac_code_o : adc_data_i; // R22
                        end
                    end
                end
                default: in_st_q <= IN_IDLE;
            endcase
        end
    end
    assign in_running_o = (in_st_q == IN_RUN);

    // tachometer delay line
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < seq_pkg::IN_GROUP_DELAY; i++) begin
                tach_dl_q[i] <= 32'h00000000;
            end
            tach_aligned_o <= 32'h00000000;
        end else if (in_running_o && samp) begin
            tach_dl_q[0] <= tach_data_i;
            for (int i = 1; i < seq_pkg::IN_GROUP_DELAY; i++) begin
                tach_dl_q[i] <= tach_dl_q[i-1];
            end
            tach_aligned_o <= tach_dl_q[seq_pkg::IN_GROUP_DELAY-1]; // R5
        end
    end

    // output sequencing
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            o_st_q <= O_IDLE;
            omode_q <= seq_pkg::OUT_WAVE;
            odly_q <= 6'h00;
            wlen_q <= '0;
            rd_q <= '0;
            ocnt_q <= 32'h00000000;
            orderly_q <= 1'b0;
            dac_code_o <= seq_pkg::DAC_ZERO_CODE; // R14
            dac_load_o <= 1'b0;
            seq_err_o <= 1'b0;
            wave_err_o <= 1'b0;
            underrun_o <= 1'b0;
        end else begin
            dac_load_o <= 1'b0;
            if (single_wr_i && !out_busy) begin
                dac_code_o <= single_data_i; // R15
                dac_load_o <= 1'b1;
            end
            if (wave_clear_i && o_st_q != O_RUN) begin
                wlen_q <= '0;
                wave_err_o <= 1'b0;
            end else if (wave_wr_i && o_st_q == O_IDLE) begin
                if (wave_full) begin
                    wave_err_o <= 1'b1; // R17
                end else begin
                    wlen_q <= wlen_q + 1'b1;
                end
            end
            if (out_start_i && !ENHANCED && in_running_o) begin
                seq_err_o <= 1'b1; // R16
            end
            case (o_st_q)
                O_IDLE: begin
                    if (ostart_ok && !(!ENHANCED && in_running_o)) begin
                        omode_q <= seq_pkg::out_mode_type'(out_mode_i);
                        ocnt_q <= out_count_i;
                        orderly_q <= 1'b0;
                        rd_q <= '0;
                        underrun_o <= 1'b0;
                        o_st_q <= O_ARM;
                    end
                end
                O_ARM: begin
                    if (out_stop_abrupt_i || out_stop_orderly_i) begin
                        o_st_q <= O_HALT;
                    end else if (cont_mode ? otrig : 1'b1) begin
                        odly_q <= 6'h00; // R18 soft trigger
                        o_st_q <= O_DLY;
                    end
                end
                O_DLY: begin
                    if (out_stop_abrupt_i) begin
                        o_st_q <= O_HALT;
                    end else if (out_tick) begin
                        odly_q <= odly_q + 6'h01;
                        if (odly_q + 6'h01 == out_lat) begin
                            o_st_q <= O_RUN; // R13
                        end
                    end
                end
                O_RUN: begin
                    if (out_stop_orderly_i) begin
                        orderly_q <= 1'b1;
                    end
                    if (out_stop_abrupt_i || cnt_end) begin
                        o_st_q <= O_HALT; // R21
                    end else if (out_tick) begin
                        if (orderly_q) begin
                            ocnt_q <= ocnt_q - 32'h00000001;
                        end
                        if (cont_mode) begin
                            if (q_valid_i) begin
                                dac_code_o <= q_data_i; // R19
                                dac_load_o <= 1'b1;
                            end else begin
                                underrun_o <= 1'b1; // R20
                                o_st_q <= O_HALT;
                            end
                        end else begin
                            dac_code_o <= wave_rd;
                            dac_load_o <= 1'b1;
                            rd_q <= rd_next; // R18
                        end
                    end
                end
                O_HALT: begin
                    if (out_start_i) begin
                        o_st_q <= O_IDLE; // R21
                    end
                end
                default: o_st_q <= O_IDLE;
            endcase
        end
    end
    assign out_running_o = (o_st_q == O_RUN);

    a_warm_discard: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        in_valid_o |-> $past(warm_done))
        else $error("input data before group delay"); // R4
    a_osc_ceiling: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        osc_word_o <= TB_MAX) else $error("timebase over ceiling"); // R3
    a_ext_rising: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (in_st_q == IN_WAIT && !slave && trig_q == seq_pkg::TRIG_EXT
         && !ext_rise && !in_stop_i) |=> in_st_q == IN_WAIT)
        else $error("start without rising edge"); // R8
    a_halt_sticky: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (o_st_q == O_HALT && !out_start_i) |=> o_st_q == O_HALT)
        else $error("trigger after stop"); // R21
    a_underrun_flag: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (run_tick && cont_mode && !q_valid_i && !out_stop_abrupt_i
         && !cnt_end) |=> underrun_o && o_st_q == O_HALT)
        else $error("underrun missed"); // R20
    a_wave_limit: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        wlen_q <= (AW+1)'(seq_pkg::FIFO_DEPTH))
        else $error("waveform over depth"); // R17
    a_single_now: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (single_wr_i && !out_busy) |=> dac_code_o == $past(single_data_i))
        else $error("single value not output"); // R15
    a_rate_range: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        rate_cl >= FS_MIN && rate_cl <= FS_TOP)
        else $error("rate out of range"); // R1
endmodule // sample_clock_trigger_dac_sequencer
`default_nettype wire

//--- core/seq_pkg.sv
// Purpose: shared constants for the sample clock, trigger and output sequencer
// Assumes: 10 MHz system clock
// Notes:   frequencies are carried in Hz, thresholds in millivolts
package seq_pkg;
    localparam int unsigned SYS_CLK_HZ      = 10_000_000;
    localparam int unsigned FS_MIN_HZ       = 195;
    localparam int unsigned FS_MAX_STD_HZ   = 52_734;
    localparam int unsigned FS_MAX_HI_HZ    = 105_469;
    localparam int unsigned MULT_LOW        = 512;
    localparam int unsigned MULT_HIGH       = 256;
    localparam int unsigned TIMEBASE_MAX_HZ = 27_000_000;
    localparam int unsigned IN_GROUP_DELAY  = 39;
    localparam int unsigned OUT_DELAY_BASE  = 34;
    localparam int unsigned OUT_DELAY_ENH   = 29;
    localparam int unsigned OUT_FS_BASE_HZ  = 46_875;
    localparam int unsigned OUT_FS_MIN_HZ   = 10_000;
    localparam int unsigned FIFO_DEPTH      = 8192;
    localparam int unsigned THR_FIXED_MV    = 1000;
    localparam int unsigned THR_MIN_MV      = 200;
    localparam int unsigned THR_MAX_MV      = 9800;
    localparam int unsigned THR_HYST_MV     = 100;
    localparam int unsigned READBACK_CH     = 7;
    localparam int unsigned THR_CH          = 0;
    localparam logic [23:0] DAC_ZERO_CODE   = 24'h000000;

    typedef enum logic [1:0] {
        TRIG_SOFT,
        TRIG_EXT,
        TRIG_THRESH
    } trig_src_type;

    typedef enum logic [1:0] {
        SYNC_NONE,
        SYNC_MASTER,
        SYNC_SLAVE
    } sync_mode_type;

    typedef enum logic [1:0] {
        OUT_SINGLE,
        OUT_WAVE,
        OUT_CONT
    } out_mode_type;
endpackage

//--- core/wave_mem.sv
// Purpose: waveform sample store with registered read data
// Assumes: single clock, one write and one read port
// Notes:   read data appear one cycle after the address
`timescale 1ns/1ps
`default_nettype none
module wave_mem #(
    parameter int unsigned DEPTH = 8192,
    parameter int unsigned WIDTH = 24,
    parameter int unsigned AW    = 13
) (
    input  wire logic             sys_clk_i,
    input  wire logic             wr_en_i,
    input  wire logic [AW-1:0]    wr_addr_i,
    input  wire logic [WIDTH-1:0] wr_data_i,
    input  wire logic [AW-1:0]    rd_addr_i,
    output logic      [WIDTH-1:0] rd_data_o
);
    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge sys_clk_i) begin
        if (wr_en_i) begin
            mem[wr_addr_i] <= wr_data_i;
        end
        rd_data_o <= mem[rd_addr_i];
    end
endmodule // wave_mem
`default_nettype wire

//--- test/host_feed.sv
// Purpose: host stand-in streaming output samples
// Assumes: ready marks a consumed word in that cycle
// Notes:   idle data shows the inverted last word
`timescale 1ns/1ps
`default_nettype none
module host_feed (
    input  wire logic        clk_i,
    input  wire logic        go_i,
    input  wire logic [23:0] base_i,
    input  wire logic        ready_i,
    output logic             valid_o,
    output logic [23:0]      data_o
);
    logic [7:0]  left_q = 8'h00;
    logic [23:0] next_q = 24'h000000;
    assign valid_o = left_q != 8'h00;
    assign data_o  = valid_o ? next_q : ~(next_q - 24'h000001);
    always_ff @(posedge clk_i) begin
        if (go_i) begin
            left_q <= 8'h05;
            next_q <= base_i;
        end else if (valid_o && ready_i) begin
            left_q <= left_q - 8'h01;
            next_q <= next_q + 24'h000001;
        end
    end
endmodule // host_feed
`default_nettype wire

//--- test/sample_clock_trigger_dac_sequencer_bench.sv
// Purpose: self-checking bench for the sequencer
// Assumes: enhanced variant, standard rate range
// Notes:   dac loads are checked in order against noted codes
`timescale 1ns/1ps
`default_nettype none
module sample_clock_trigger_dac_sequencer_bench;
    logic        clk = 0, rst = 1, ist = 0, isp = 0, ext = 0, ltr = 0;
    logic        swr = 0, wwr = 0, ost = 0, oab = 0, go = 0, rdy, vld;
    logic        irun, isam, ival, load, urun, orun;
    logic [1:0]  trig = 0, sync = 0, mode = 0;
    logic [16:0] rate = 17'h00064, orate = 17'h0CDFE;
    logic [18:0] misc = 0;
    logic [23:0] sd = 0, wd = 0, qd, base = 0, dac, adc = 0, w[3];
    logic [31:0] tach = 0;
    logic [24:0] osc;
    logic [23:0] exq[$];
    int          err_total = 0, num_checks = 0, i, n;
    int          rt[3] = '{100, 50000, 60000};
    sample_clock_trigger_dac_sequencer sample_clock_trigger_dac_sequencer_i (
        .sys_clk_i(clk), .rst_i(rst), .in_rate_hz_i(rate),
        .trig_src_i(trig), .sync_mode_i(sync), .in_start_i(ist),
        .in_stop_i(isp), .in_buffers_done_i(1'b0), .ext_trig_i(ext),
        .link_trig_i(ltr), .link_clk_i(misc[18]), .ch0_mv_i(misc[13:0]),
        .ch0_neg_i(misc[14]), .thr_mv_i(14'h03E8), .list_ch_i(misc[17:15]),
        .adc_data_i(adc), .tach_data_i(tach), .out_mode_i(mode),
        .out_rate_hz_i(orate), .single_wr_i(swr), .single_data_i(sd),
        .wave_wr_i(wwr), .wave_data_i(wd), .wave_clear_i(1'b0),
        .out_start_i(ost), .out_stop_orderly_i(1'b0),
        .out_stop_abrupt_i(oab), .out_count_i(32'h00000000),
        .q_valid_i(vld), .q_data_i(qd), .q_ready_o(rdy), .osc_word_o(osc),
        .in_running_o(irun), .in_sample_o(isam), .in_valid_o(ival),
        .in_data_o(), .tach_aligned_o(), .out_running_o(orun),
        .dac_code_o(dac), .dac_load_o(load), .seq_err_o(), .wave_err_o(),
        .underrun_o(urun));
    host_feed host_feed_i (.clk_i(clk), .go_i(go), .base_i(base),
        .ready_i(rdy), .valid_o(vld), .data_o(qd));
    initial forever #50 clk = ~clk;
    always @(negedge clk) begin
        adc = $urandom;
        tach = $urandom;
        misc = $urandom;
    end
    task automatic finish_test;
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            err_total++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic start_in(logic [1:0] s, logic [1:0] y);
        trig = s;
        sync = y;
        ist = 1;
        @(negedge clk);
        ist = 0;
    endtask
    task automatic stop_in;
        isp = 1;
        @(negedge clk);
        isp = 0;
        repeat (4) @(negedge clk);
        chk("stop", 0, irun);
    endtask
    task automatic pulse_start;
        ost = 1;
        @(negedge clk);
        ost = 0;
        @(negedge clk);
    endtask
    task automatic drain;
        for (n = 0; n < 20000 && exq.size() > 0; n++)
            @(negedge clk);
        if (n >= 20000) begin
            err_total++;
            finish_test;
        end
    endtask
    always @(posedge clk) begin
        if (!rst && load === 1'b1) begin
            if (exq.size() == 0)
                chk("load", 0, 1);
            else
                chk("dac", exq.pop_front(), dac);
        end
    end
    initial begin
        void'($urandom(32'haef41dde));
        repeat (12) @(negedge clk);
        rst = 0;
        chk("zero", 0, dac);
        foreach (rt[k]) begin
            rate = rt[k][16:0];
            repeat (4) @(negedge clk);
            n = rt[k] < 195 ? 195 : rt[k] > 52734 ? 52734 : rt[k];
            chk("osc", n * seq_pkg::MULT_LOW, {7'h00, osc});
        end
        for (i = 0; i < 3; i++) begin
            sd = $urandom;
            exq.push_back(sd);
            swr = 1;
            @(negedge clk);
        end
        swr = 0;
        ext = 1;
        start_in(2'h0, 2'h0);
        n = 0;
        for (i = 0; i < 20000 && ival !== 1; i++) begin
            @(posedge clk);
            n += isam === 1;
        end
        if (i >= 20000) begin
            err_total++;
            finish_test;
        end
        @(negedge clk);
        chk("lat", 40, n);
        chk("soft", 1, irun);
        stop_in;
        start_in(2'h1, 2'h0);
        trig = 0;
        repeat (4) @(negedge clk);
        ext = 0;
        repeat (8) @(negedge clk);
        chk("fall", 0, irun);
        ext = 1;
        repeat (8) @(negedge clk);
        chk("rise", 1, irun);
        stop_in;
        start_in(2'h1, 2'h2);
        ext = 0;
        repeat (8) @(negedge clk);
        ext = 1;
        repeat (8) @(negedge clk);
        chk("slv", 0, irun);
        ltr = 1;
        repeat (8) @(negedge clk);
        chk("lnk", 1, irun);
        stop_in;
        mode = 1;
        for (i = 0; i < 3; i++) begin
            w[i] = $urandom;
            wd = w[i];
            wwr = 1;
            @(negedge clk);
        end
        wwr = 0;
        for (i = 0; i < 7; i++)
            exq.push_back(w[i % 3]);
        pulse_start;
        drain;
        oab = 1;
        @(negedge clk);
        oab = 0;
        repeat (600) @(negedge clk);
        chk("abrupt", 0, orun);
        start_in(2'h0, 2'h0);
        stop_in;
        mode = 2;
        base = $urandom;
        for (i = 0; i < 5; i++)
            exq.push_back(base + i[23:0]);
        go = 1;
        @(negedge clk);
        go = 0;
        pulse_start;
        pulse_start;
        drain;
        repeat (600) @(negedge clk);
        chk("urun", 1, urun);
        finish_test;
    end
endmodule // sample_clock_trigger_dac_sequencer_bench
`default_nettype wire
